// file: design/uepc_buf.sv
/*
 holds a two-entry buffer with valid and ready on both sides.
 assumes both sides run on the same clock.
*/
`default_nettype none
module uepc_buf #(
   parameter int W = 31
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic inValid,
   input wire logic [W-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [W-1:0] outData,
   input wire logic outReady
);
   // --------------------------------------------------
   // state
   // --------------------------------------------------
   typedef struct packed {
      logic [W-1:0] head;   // entry on the output
      logic [W-1:0] spare;  // second entry
      logic headValid;
      logic spareValid;
   } uepc_buf_state_t;
   uepc_buf_state_t stateReg;
   uepc_buf_state_t stateNext;
   logic pop;
   logic push;
   assign pop = stateReg.headValid & outReady;
   assign push = inValid & ~stateReg.spareValid;
   // next state: pop first, then push into the free slot
   always_comb begin
      stateNext = stateReg;
      if (pop) begin
         stateNext.headValid = stateReg.spareValid;
         stateNext.head = stateReg.spare;
         stateNext.spareValid = 1'b0;
      end
      if (push) begin
         if (!stateNext.headValid) begin
            stateNext.head = inData;
            stateNext.headValid = 1'b1;
         end else begin
            stateNext.spare = inData;
            stateNext.spareValid = 1'b1;
         end
      end
   end
   // register the state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stateReg <= '0;
      end else begin
         stateReg <= stateNext;
      end
   end
   assign inReady = ~stateReg.spareValid;
   assign outValid = stateReg.headValid;
   assign outData = stateReg.head;
endmodule
`default_nettype wire

// file: design/uepc_resp.sv
/*
 holds the handshake decision for one transaction on one endpoint.
 assumes the caller selects the endpoint's control settings.
*/
`default_nettype none
module uepc_resp
   import uepc_pkg::*;
(
   input wire uepc_req_t req,
   input wire uepc_ctl_t ctl,
   input wire logic [LEN_W-1:0] len,
   input wire logic [BUF_W-1:0] bufAddr,
   output uepc_resp_t resp
);
   // --------------------------------------------------
   // decision
   // --------------------------------------------------
   // purely combinational: no state
   always_comb begin
      resp = '0;
      resp.ep = req.ep;
      resp.isIn = req.isIn;
      resp.len = len;
      resp.bufAddr = bufAddr;
      resp.dataPid1 = ctl.txTog;
      resp.toggleOk = req.iso | (req.rxPid1 == ctl.rxTog);
      if (req.ep == 2'h3) begin
         // no such endpoint here
         resp.hs = UEPC_HS_STALL;
      end else if (req.iso) begin
         // isochronous: data goes, no handshake
         resp.hs = UEPC_HS_NONE;
         resp.sendData = req.isIn;
      end else if (req.isIn) begin
         resp.hs = uepc_hs_t'({1'b0, ctl.inHs});
         resp.sendData = ~ctl.inHs[1];
      end else begin
         resp.hs = uepc_hs_t'({1'b0, ctl.outHs});
      end
   end
endmodule
`default_nettype wire

// file: design/uepc_top.sv
/*
 holds the endpoint 5-7 configuration block: registers behind an
 ahb-lite slave, handshake decisions for the serial engine, and
 toggle auto flip on completed transfers.
 assumes the serial engine and the bus run on mclk.
 assumes the engine holds a request until it is taken.
 assumes hwdata byte lanes follow the low address bits.
 assumes software writes 4-byte aligned buffer starts.
*/
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
// Function
// - endpoint 7 buffer start keeps 15 bits
// - endpoint 7 send and receive always enabled
// - seven-bit send byte count per endpoint
// - bit 7 selects expected out data pid
// - bit 6 selects in data pid
// - bit 4 enables toggle auto flip
// - out handshake from two-bit field
// - in handshake from two-bit field
// - isochronous skips toggle check and handshake
// - combined word control high, length low
`default_nettype none
module uepc_top
   import uepc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // transaction requests from the serial engine
   input wire logic reqValid,
   input wire uepc_req_t reqInfo,
   output logic reqReady,
   // decisions back to the serial engine
   output logic respValid,
   output uepc_resp_t respInfo,
   input wire logic respReady,
   // completed transfers
   input wire logic doneValid,
   input wire uepc_done_t doneInfo,
   // endpoint 7 buffer start for the dma
   output logic [BUF_W-1:0] ep7BufStart
);
   // --------------------------------------------------
   // state
   // --------------------------------------------------
   // one field per register plus bus and buffer tracking
   typedef struct packed {
      logic [BUF_W-1:0] ep7Buf;              // buffer start
      uepc_ctl_t [NUM_EP-1:0] ctl;           // control halves
      logic [NUM_EP-1:0][LEN_W-1:0] len;     // send byte counts
      // bus data phase and buffer fill tracking
      logic dAct;                            // data phase pending
      logic dWrite;                          // pending is a write
      logic [7:0] dAddr;                     // word byte address
      logic [3:0] dBe;                       // byte lanes
      logic [31:0] rdata;                    // read data out
      logic [1:0] occ;                       // decisions in the buffer
      logic rdy;                             // buffer has a free slot
   } uepc_state_t;
   uepc_state_t stateReg;
   uepc_state_t stateNext;
   // always_comb builds stateNext,
   // always_ff keeps it

   // --------------------------------------------------
   // helpers
   // --------------------------------------------------
   // byte lanes of one transfer
   // byte: one lane by the low two bits
   // half: lanes 1:0 or 3:2 by bit 1
   // word and wider: all four lanes
   function automatic logic [3:0] laneMask(
      input logic [2:0] size,
      input logic [1:0] low
   );
      logic [3:0] m;
      m = 4'h0;
      case (size)
         3'h0: m = 4'(4'h1 << low);
         3'h1: m = low[1] ? 4'hC : 4'h3;
         default: m = 4'hF;
      endcase
      return m;
   endfunction

   // byte address of an endpoint's combined word
   // ep5 first, one stride per endpoint
   function automatic logic [7:0] epOfs(input int i);
      return OFS_EP5_CTL + 8'(i) * OFS_EP_STRIDE;
   endfunction

   // read value of a word, reserved bits zero
   // called with the next state, so a read
   // right after a write sees the new value
   function automatic logic [31:0] readWord(
      input uepc_state_t s,
      input logic [7:0] a
   );
      logic [31:0] w;
      w = 32'h0000_0000;
      // endpoint 7 start: low 15 bits only
      if (a == OFS_EP7_BUF) begin
         w[BUF_W-1:0] = s.ep7Buf;
      end
      // one combined word per endpoint
      for (int i = 0; i < NUM_EP; i++) begin
         if (a == epOfs(i)) begin
            w[LEN_W-1:0] = s.len[i];
            w[POS_CTL+:8] = ctlToByte(s.ctl[i]);
         end
      end
      return w;
   endfunction

   // --------------------------------------------------
   // per-endpoint write decode
   // --------------------------------------------------
   logic [NUM_EP-1:0] epLenWr;   // length half written now
   logic [NUM_EP-1:0] epCtlWr;   // control half written now
   // one decode slice per combined word
   for (genvar gi = 0; gi < NUM_EP; gi++) begin : g_ep
      logic hit;                 // pending write aims here
      assign hit = stateReg.dAct & stateReg.dWrite & (stateReg.dAddr == epOfs(gi));
      assign epLenWr[gi] = hit & stateReg.dBe[0];
      assign epCtlWr[gi] = hit & stateReg.dBe[2];
   end

   // --------------------------------------------------
   // decision for the current request
   // --------------------------------------------------
   // settings of the requested endpoint;
   // code 3 sees all-zero settings
   logic reqEpOk;
   uepc_ctl_t selCtl;
   logic [LEN_W-1:0] selLen;
   logic [BUF_W-1:0] selBuf;
   uepc_resp_t decision;
   logic bufInReady;
   logic take;

   // pick the endpoint's settings; endpoint 7 needs no enable
   // only endpoint 7 hands on its buffer start;
   // endpoints 5 and 6 keep theirs elsewhere
   always_comb begin
      reqEpOk = (reqInfo.ep < 2'(NUM_EP));
      selCtl = '0;
      selLen = RST_LEN;
      selBuf = RST_BUF;
      if (reqEpOk) begin
         selCtl = stateReg.ctl[reqInfo.ep];
         selLen = stateReg.len[reqInfo.ep];
      end
      // endpoint 7 also hands on its buffer start
      if (reqInfo.ep == 2'(EP7_IDX)) begin
         selBuf = stateReg.ep7Buf;
      end
   end

   // handshake, data pid and toggle check
   uepc_resp u_resp (
      .req(reqInfo),
      .ctl(selCtl),
      .len(selLen),
      .bufAddr(selBuf),
      .resp(decision)
   );

   // a request is taken only when the buffer has room
   // reqReady tracks the same free slot
   assign take = reqValid & bufInReady;

   // --------------------------------------------------
   // two-entry decision buffer
   // --------------------------------------------------
   // decisions wait here while the engine stalls;
   // one can be taken while another waits
   uepc_buf #(
      .W($bits(uepc_resp_t))
   ) u_buf (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .inValid(take),
      .inData(decision),
      .inReady(bufInReady),
      .outValid(respValid),
      .outData(respInfo),
      .outReady(respReady)
   );

   // --------------------------------------------------
   // next state
   // --------------------------------------------------
   // data phase write, toggle flip, then address phase
   // the flip sees a control byte written now,
   // and the read data sees both, so back to
   // back transfers stay coherent
   always_comb begin
      logic [7:0] ab;
      ab = 8'h00;
      stateNext = stateReg;
      // write of the pending data phase
      // address and lanes captured a cycle earlier
      if (stateReg.dAct && stateReg.dWrite) begin
         if (stateReg.dAddr == OFS_EP7_BUF) begin
            // only the low 15 bits are kept
            if (stateReg.dBe[0]) begin
               stateNext.ep7Buf[7:0] = hwdata[7:0];
            end
            // bit 15 of lane 1 has no storage
            if (stateReg.dBe[1]) begin
               stateNext.ep7Buf[14:8] = hwdata[14:8];
            end
         end
         for (int i = 0; i < NUM_EP; i++) begin
            // lane 0: length half; lane 2: control half
            if (epLenWr[i]) begin
               stateNext.len[i] = hwdata[LEN_W-1:0];
            end
            if (epCtlWr[i]) begin
               ab = hwdata[POS_CTL+:8];
               stateNext.ctl[i] = byteToCtl(ab);
            end
         end
      end
      // completed transfer: flip applied after any write
      // iso, unknown endpoints and a cleared
      // flip enable leave the toggles alone
      if (doneValid && !doneInfo.iso && doneInfo.ep < 2'(NUM_EP)) begin
         if (stateNext.ctl[doneInfo.ep].autoFlip) begin
            // in flips the sent pid, out the expected
            if (doneInfo.isIn) begin
               stateNext.ctl[doneInfo.ep].txTog =
                  ~stateNext.ctl[doneInfo.ep].txTog;
            end else begin
               stateNext.ctl[doneInfo.ep].rxTog =
                  ~stateNext.ctl[doneInfo.ep].rxTog;
            end
         end
      end
      // buffer fill, so reqReady comes from a flop
      stateNext.occ = stateReg.occ + 2'(take) - 2'(respValid & respReady);
      stateNext.rdy = (stateNext.occ != 2'h2);
      // address phase
      // capture a taken transfer; hwdata
      // only arrives in the next cycle
      stateNext.dAct = hsel & hready & htrans[1];
      stateNext.dWrite = hwrite;
      stateNext.dAddr = {haddr[7:2], 2'b00};
      stateNext.dBe = laneMask(hsize, haddr[1:0]);
      // read data from the updated registers
      // hrdata holds until the next read
      if (stateNext.dAct && !hwrite) begin
         stateNext.rdata = readWord(stateNext, stateNext.dAddr);
      end
   end

   // --------------------------------------------------
   // registers
   // --------------------------------------------------
   // every field resets to zero except rdy, which resets to one
   // synchronous, active high, one edge suffices
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stateReg <= '0;
         stateReg.ep7Buf <= RST_BUF;
         stateReg.rdy <= 1'b1;                           // empty buffer
      end else begin
         stateReg <= stateNext;
      end
   end

   // --------------------------------------------------
   // outputs
   // --------------------------------------------------
   // zero wait states, always okay
   // no field needs extra time, so no
   // transfer is stretched or refused
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         // ready even in reset
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         // every transfer ends at once
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
   // outputs straight from registered state
   assign hrdata = stateReg.rdata;
   assign ep7BufStart = stateReg.ep7Buf;
   assign reqReady = stateReg.rdy;
endmodule
`default_nettype wire

// file: include/uepc_pkg.sv
/*
 holds the constants, field layouts and carrier structs of the
 endpoint 5-7 configuration block.
 assumes one clock and a synchronous active-high reset.
*/
`default_nettype none
package uepc_pkg;
   // --------------------------------------------------
   // sizes
   // --------------------------------------------------
   localparam int NUM_EP = 3;        // endpoints 5, 6, 7
   localparam int LEN_W = 7;         // send byte count width
   localparam int BUF_W = 15;        // buffer start width
   localparam int EP7_IDX = 2;       // index of endpoint 7
   // --------------------------------------------------
   // byte offsets of the registers
   // --------------------------------------------------
   localparam logic [7:0] OFS_EP7_BUF = 8'h00;
   localparam logic [7:0] OFS_EP5_CTL = 8'h04;
   localparam logic [7:0] OFS_EP_STRIDE = 8'h04;
   // --------------------------------------------------
   // field positions
   // --------------------------------------------------
   localparam int POS_CTL = 16;      // control half in combined word
   localparam int BIT_RXTOG = 7;     // within control byte
   localparam int BIT_TXTOG = 6;
   localparam int BIT_AUTO = 4;
   localparam int POS_OUT_HS = 2;
   localparam int POS_IN_HS = 0;
   // --------------------------------------------------
   // reset values
   // --------------------------------------------------
   localparam logic [LEN_W-1:0] RST_LEN = 7'h00;
   localparam logic [BUF_W-1:0] RST_BUF = 15'h0000;
   // --------------------------------------------------
   // types
   // --------------------------------------------------
   typedef enum logic [2:0] {
      UEPC_HS_ACK = 3'b000,
      UEPC_HS_NYET = 3'b001,
      UEPC_HS_NAK = 3'b010,
      UEPC_HS_STALL = 3'b011,
      UEPC_HS_NONE = 3'b100
   } uepc_hs_t;
   typedef struct packed {
      logic rxTog;          // expected out data pid
      logic txTog;          // in data pid
      logic autoFlip;       // toggle auto flip
      logic [1:0] outHs;    // out handshake
      logic [1:0] inHs;     // in handshake
   } uepc_ctl_t;
   typedef struct packed {
      logic [1:0] ep;       // 0..2 = endpoint 5..7
      logic isIn;           // in token, else out
      logic iso;            // isochronous endpoint
      logic rxPid1;         // received data pid was data1
   } uepc_req_t;
   typedef struct packed {
      logic [1:0] ep;
      logic isIn;
      uepc_hs_t hs;         // handshake to give
      logic sendData;       // in: send the data packet
      logic dataPid1;       // in: data pid to send
      logic toggleOk;       // out: pid matched
      logic [LEN_W-1:0] len;
      logic [BUF_W-1:0] bufAddr;
   } uepc_resp_t;
   typedef struct packed {
      logic [1:0] ep;
      logic isIn;
      logic iso;
   } uepc_done_t;
   // control byte to and from its struct
   function automatic logic [7:0] ctlToByte(input uepc_ctl_t c);
      logic [7:0] b;
      b = 8'h00;
      b[BIT_RXTOG] = c.rxTog;
      b[BIT_TXTOG] = c.txTog;
      b[BIT_AUTO] = c.autoFlip;
      b[POS_OUT_HS+:2] = c.outHs;
      b[POS_IN_HS+:2] = c.inHs;
      return b;
   endfunction
   function automatic uepc_ctl_t byteToCtl(input logic [7:0] b);
      uepc_ctl_t c;
      c.rxTog = b[BIT_RXTOG];
      c.txTog = b[BIT_TXTOG];
      c.autoFlip = b[BIT_AUTO];
      c.outHs = b[POS_OUT_HS+:2];
      c.inHs = b[POS_IN_HS+:2];
      return c;
   endfunction
endpackage
`default_nettype wire

// file: tb/tb_uepc_top.sv
/*
 self-checking bench of the endpoint 5-7 configuration block.
 assumes the engine model in uepc_engine_model.sv.
*/
`default_nettype none
module tb_uepc_top;
   import uepc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, sys_rst, hwrite, hreadyout, hresp, reqValid, reqReady;
   logic respValid, respReady, doneValid;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [BUF_W-1:0] ep7BufStart;
   uepc_req_t reqInfo;
   uepc_resp_t respInfo, r;
   uepc_done_t doneInfo;
   int miscompares = 0;
   int checkCount = 0;
   int cyc = 0;
   uepc_top uepc_top_inst (.mclk(mclk), .sys_rst(sys_rst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .reqValid(reqValid), .reqInfo(reqInfo), .reqReady(reqReady),
      .respValid(respValid), .respInfo(respInfo), .respReady(respReady),
      .doneValid(doneValid), .doneInfo(doneInfo), .ep7BufStart(ep7BufStart));
   uepc_engine_model uepc_engine_model_inst (.mclk(mclk), .reqValid(reqValid),
      .reqInfo(reqInfo), .reqReady(reqReady), .respValid(respValid),
      .respInfo(respInfo), .respReady(respReady), .doneValid(doneValid),
      .doneInfo(doneInfo));
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checkCount, miscompares);
      if (miscompares == 0 && checkCount > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         miscompares++;
      end
   endtask
   // ahb-lite single transfer
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
      input logic [2:0] s, output logic [31:0] q);
      haddr <= {24'h000000, a};
      hwrite <= w;
      hsize <= s;
      htrans <= 2'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic bw(input logic [7:0] a, input logic [31:0] d, input logic [2:0] s);
      logic [31:0] q;
      bus(a, 1'b1, d, s, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h00000000, 3'h2, q);
      chk(q, e);
      chk(32'({hreadyout, hresp}), 32'h00000002);
   endtask
   // control byte and count as one word
   task automatic cw(input logic [7:0] a, input logic [7:0] c, input logic [6:0] l);
      bw(a, {8'h00, c, 9'h000, l}, 3'h2);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs();
      for (int i = 0; i < 16; i += 4) rc(8'(i), 32'h00000000);
      bw(8'h00, 32'hFFFFFFFF, 3'h2);
      rc(8'h00, 32'h00007FFF);
      bw(8'h04, 32'hFFFFFFFF, 3'h2);
      rc(8'h04, 32'h00DF007F);
      bw(8'h0A, 32'h00C30000, 3'h1);
      bw(8'h08, 32'h00000055, 3'h1);
      rc(8'h08, 32'h00C30055);
      rc(8'h10, 32'h00000000);
   endtask
   task automatic t_hs();
      for (int k = 0; k < 4; k++) begin
         cw(8'h04, {6'b010000, 2'(k)}, 7'h12);
         uepc_engine_model_inst.request({2'd0, 3'b100});
         uepc_engine_model_inst.getResp(0, r);
         chk(32'({r.bufAddr, r.hs, r.sendData, r.dataPid1, r.len}),
            32'({15'h0000, 1'b0, 2'(k), k < 2, 1'b1, 7'h12}));
         cw(8'h08, {k[0], 3'b000, 2'(k), 2'b00}, 7'h00);
         uepc_engine_model_inst.request({2'd1, 3'b001});
         uepc_engine_model_inst.getResp(1, r);
         chk(32'({r.hs, r.toggleOk}), 32'({1'b0, 2'(k), k[0]}));
      end
      cw(8'h08, 8'h0C, 7'h00);
      uepc_engine_model_inst.request({2'd1, 3'b011});
      uepc_engine_model_inst.getResp(0, r);
      chk(32'({r.hs, r.toggleOk}), 32'h00000009);
   endtask
   task automatic t_ep7();
      bw(8'h00, 32'h00001234, 3'h2);
      cw(8'h0C, 8'h00, 7'h05);
      uepc_engine_model_inst.request({2'd2, 3'b100});
      uepc_engine_model_inst.getResp(0, r);
      chk(32'({r.bufAddr, r.len, r.dataPid1, r.hs}), 32'({15'h1234, 7'h05, 4'h0}));
      uepc_engine_model_inst.request({2'd3, 3'b100});
      uepc_engine_model_inst.getResp(0, r);
      chk(32'({r.hs, r.sendData}), 32'h00000006);
   endtask
   task automatic t_auto();
      cw(8'h08, 8'h10, 7'h00);
      uepc_engine_model_inst.done({2'd1, 2'b10});
      rc(8'h08, 32'h00500000);
      uepc_engine_model_inst.done({2'd1, 2'b00});
      rc(8'h08, 32'h00D00000);
      uepc_engine_model_inst.done({2'd1, 2'b11});
      rc(8'h08, 32'h00D00000);
      cw(8'h08, 8'h00, 7'h00);
      uepc_engine_model_inst.done({2'd1, 2'b10});
      rc(8'h08, 32'h00000000);
   endtask
   task automatic t_stall();
      fork
         begin
            for (int i = 0; i < 3; i++) begin
               uepc_engine_model_inst.request({2'(i), 3'b100});
               @(posedge mclk);
            end
         end
      join_none
      repeat (8) @(posedge mclk);
      chk(32'(reqReady), 32'h00000000);
      for (int i = 0; i < 3; i++) begin
         uepc_engine_model_inst.getResp(3, r);
         chk(32'(r.ep), 32'(i));
      end
   endtask
   // ------------------------------
   // clock, timeout, main sequence
   // ------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      sys_rst = 1'b1;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_hs();
      t_ep7();
      t_auto();
      t_stall();
      finish_test();
   end
endmodule
`default_nettype wire

// file: tb/uepc_engine_model.sv
/*
 serial engine model: issues requests, takes decisions, reports done.
 assumes tasks are called just after a rising edge of mclk.
*/
`default_nettype none
module uepc_engine_model
   import uepc_pkg::*;
(
   input wire logic mclk,
   output logic reqValid,
   output uepc_req_t reqInfo,
   input wire logic reqReady,
   input wire logic respValid,
   input wire uepc_resp_t respInfo,
   output logic respReady,
   output logic doneValid,
   output uepc_done_t doneInfo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reqValid = 1'b0;
      reqInfo = '0;
      respReady = 1'b0;
      doneValid = 1'b0;
      doneInfo = '0;
   end
   // hold the request until taken, then scramble the data lines
   task automatic request(input uepc_req_t r);
      reqValid <= 1'b1;
      reqInfo <= r;
      do @(posedge mclk); while (reqReady !== 1'b1);
      reqValid <= 1'b0;
      reqInfo <= ~r;
   endtask
   // stall for slow cycles, then take one decision
   task automatic getResp(input int slow, output uepc_resp_t r);
      repeat (slow) @(posedge mclk);
      respReady <= 1'b1;
      do @(posedge mclk); while (respValid !== 1'b1);
      r = respInfo;
      respReady <= 1'b0;
   endtask
   // one-cycle completion pulse
   task automatic done(input uepc_done_t d);
      doneValid <= 1'b1;
      doneInfo <= d;
      @(posedge mclk);
      doneValid <= 1'b0;
      doneInfo <= ~d;
   endtask
endmodule
`default_nettype wire

// file: tb/uepc_top_assertions.sv
/*
 checker of the endpoint 5-7 configuration block ports.
 assumes one clock, mclk, and a synchronous active-high sys_rst.
*/
`default_nettype none
module uepc_top_assertions
   import uepc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic respValid,
   input wire uepc_resp_t respInfo,
   input wire logic respReady,
   input wire logic [BUF_W-1:0] ep7BufStart
);
   // ------------------------------
   // data phase tracking
   // ------------------------------
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic dWr; // write in data phase
   logic dRd; // read in data phase
   logic [7:0] dAddr;
   logic [2:0] dSize;
   // capture the taken address phase
   always_ff @(posedge mclk) begin
      dWr <= !sys_rst && hsel && hready && htrans[1] && hwrite;
      dRd <= !sys_rst && hsel && hready && htrans[1] && !hwrite;
      dAddr <= haddr[7:0];
      dSize <= hsize;
   end
   sequence sTake;
      reqValid && reqReady && !respValid;
   endsequence
   // ------------------------------
   // assertions
   // ------------------------------
   a_reset_clear: assert property (disable iff (1'b0)
      sys_rst |=> !respValid && ep7BufStart == 15'h0000) else $error("reset state wrong");
   a_buf_write: assert property (dWr && dAddr == 8'h00 && dSize == 3'h2
      |=> ep7BufStart == $past(hwdata[14:0])) else $error("buffer start not 15 bits");
   a_rd_unmapped: assert property (dRd && dAddr > 8'h0F
      |-> hrdata == 32'h00000000) else $error("unmapped read not zero");
   a_rd_bufres: assert property (dRd && dAddr == 8'h00
      |-> hrdata[31:15] == 17'h00000) else $error("buffer reserved not zero");
   a_rd_ctlres: assert property (dRd && dAddr inside {8'h04, 8'h08, 8'h0C}
      |-> {hrdata[31:24], hrdata[21], hrdata[15:7]} == 18'h00000) else $error("ctl reserved");
   a_in_send: assert property (respValid && respInfo.isIn
      && respInfo.hs inside {UEPC_HS_ACK, UEPC_HS_NYET} |-> respInfo.sendData)
      else $error("in data not sent");
   a_in_refuse: assert property (respValid && respInfo.isIn && respInfo.ep != 2'd3
      && respInfo.hs inside {UEPC_HS_NAK, UEPC_HS_STALL} |-> !respInfo.sendData)
      else $error("in data sent on refusal");
   a_iso_ok: assert property (respValid && respInfo.hs == UEPC_HS_NONE
      |-> respInfo.toggleOk) else $error("iso toggle checked");
   a_ep7_addr: assert property (respValid && respInfo.isIn && respInfo.ep == 2'd2
      && respInfo.hs == UEPC_HS_ACK |-> respInfo.bufAddr == ep7BufStart)
      else $error("ep7 buffer start missing");
   a_resp_next: assert property (sTake |=> respValid)
      else $error("response late");
   a_resp_hold: assert property (respValid && !respReady
      |=> respValid && $stable(respInfo)) else $error("response dropped");
endmodule
bind uepc_top uepc_top_assertions uepc_top_assertions_inst (.mclk(mclk), .sys_rst(sys_rst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .reqValid(reqValid),
   .reqReady(reqReady), .respValid(respValid), .respInfo(respInfo),
   .respReady(respReady), .ep7BufStart(ep7BufStart));
`default_nettype wire
